//--- src/ctp_postproc.sv
`timescale 1ns/1ps
`default_nettype none
module ctp_postproc #(
    parameter int unsigned BIT_CYC = ctp_pkg::BIT_CYC_DEF
) (
    input  wire logic                    mclk_i,
    input  wire logic                    reset_n_i,
    input  wire logic [7:0]              reg_addr_i,
    input  wire logic [7:0]              reg_wdata_i,
    input  wire logic                    reg_wr_i,
    input  wire logic                    reg_rd_i,
    output logic      [7:0]              reg_rdata_o,
    input  wire logic                    smp_valid_i,
    input  wire logic [1:0]              smp_cpu_i,
    input  wire logic [ctp_pkg::SMP_W-1:0] smp_data_i,
    input  wire logic                    smp_fcs_ok_i,
    input  wire logic                    local_valid_i,
    input  wire logic [9:0]              local_temp_i,
    input  wire logic [8:0]              fan_behavior_i,
    output logic                         poll_start_o,
    output logic      [2:0]              poll_cpu_count_o,
    output logic                         smbalert_n_o,
    output logic                         swap_mode_o,
    output logic                         hyst_swap_o,
    output logic      [2:0]              fan_zone_swap_o
);
    import ctp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State.
    typedef struct packed {
        logic [3:0][7:0]       value;
        logic [7:0]            local_temp;
        logic [7:0]            low;
        logic [7:0]            high;
        logic [7:0]            cfg1;
        logic [7:0]            moncfg;
        logic [7:0]            cpucfg;
        logic [3:0][7:0]       offs;
        logic [7:0]            stat3;
        logic [7:0]            statx;
        logic [3:0][ACC_W-1:0] acc;
        logic [3:0][SMP_W-1:0] rmax;
        logic [3:0]            rgood;
        logic [3:0]            igood;
        logic [15:0]           timer;
        logic [12:0]           rdcnt;
        logic                  run;
        logic                  upd;
        logic [7:0]            rdata;
        logic                  poll;
        logic [2:0]            ncpu;
        logic                  alert_n;
        logic                  swap;
        logic                  hyst;
        logic [2:0]            fz;
    } ctp_state_s;

    ctp_state_s s;
    ctp_state_s n;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Error codes are a small window at the bottom of the signed range.
    function automatic logic is_err(input logic [SMP_W-1:0] d);
        return (d >= ERR_LO) && (d <= ERR_HI);
    endfunction : is_err

    // Read count is a power of two so the average is a plain shift.
    function automatic logic [3:0] rd_shift(input logic [2:0] code);
        case (code)
            3'h0:    rd_shift = 4'h0;
            3'h1:    rd_shift = 4'h1;
            3'h2:    rd_shift = 4'h2;
            3'h3:    rd_shift = 4'h3;
            3'h4:    rd_shift = 4'h4;
            3'h5:    rd_shift = 4'h6;
            3'h6:    rd_shift = 4'h8;
            default: rd_shift = 4'hc;
        endcase
    endfunction : rd_shift

    // Saturating signed add keeps a large offset from wrapping hot into cold.
    function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] sum;
        sum = {a[7], a} + {b[7], b};
        if (sum[8] != sum[7]) begin
            sat_add = sum[8] ? 8'h80 : 8'h7f;
        end else begin
            sat_add = sum[7:0];
        end
    endfunction : sat_add

    // In swap mode each remote-1 location and its channel-0 partner trade places.
    function automatic logic [7:0] remap(input logic [7:0] a, input logic sw);
        remap = a;
        if (sw) begin
            case (a)
                ADDR_R1_VAL:  remap = ADDR_VAL0;
                ADDR_VAL0:    remap = ADDR_R1_VAL;
                ADDR_R1_LOW:  remap = ADDR_LOW;
                ADDR_LOW:     remap = ADDR_R1_LOW;
                ADDR_R1_HIGH: remap = ADDR_HIGH;
                ADDR_HIGH:    remap = ADDR_R1_HIGH;
                ADDR_R1_OFF:  remap = ADDR_OFF0;
                ADDR_OFF0:    remap = ADDR_R1_OFF;
                default:      remap = a;
            endcase
        end
    endfunction : remap

    logic [7:0]  maddr;
    logic [15:0] round_cyc;
    logic [12:0] reads_m1;
    logic [3:0]  shift;
    assign maddr     = remap(reg_addr_i, s.cfg1[SWAP_BIT]); // [R13] [R14]
    assign shift     = rd_shift(s.cfg1[SMOOTH_MSB:SMOOTH_LSB]); // [R4]
    assign reads_m1  = 13'((32'd1 << shift) - 32'd1);
    assign round_cyc = 16'(32'(s.ncpu) * BITS_PER_RD * BIT_CYC + IDLE_CYC); // [R6]

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic.
    always_comb begin
        logic              rnd_end;
        logic              int_end;
        logic [ACC_W-1:0]  sum;
        logic [ACC_W-1:0]  avg;
        logic [7:0]        corr;
        logic              good;
        n = s;
        rnd_end = 1'b0;
        int_end = 1'b0;
        sum = '0;
        avg = '0;
        corr = ZERO8;
        good = 1'b0;
        n.poll = 1'b0;
        n.upd = 1'b0;

        // Register writes; only locations held here are decoded.
        if (reg_wr_i) begin
            case (maddr)
                ADDR_LOW:    n.low = reg_wdata_i; // [R2]
                ADDR_HIGH:   n.high = reg_wdata_i; // [R2]
                ADDR_CFG1:   n.cfg1 = reg_wdata_i;
                ADDR_MONCFG: n.moncfg = reg_wdata_i;
                ADDR_CPUCFG: n.cpucfg = reg_wdata_i;
                ADDR_OFF0:   n.offs[0] = reg_wdata_i; // [R3]
                ADDR_OFF1:   n.offs[1] = reg_wdata_i; // [R3]
                ADDR_OFF2:   n.offs[2] = reg_wdata_i; // [R3]
                ADDR_OFF3:   n.offs[3] = reg_wdata_i; // [R3]
                default:     n.rdata = s.rdata;
            endcase
        end

        // Reads return the old status and clear it; events below still win.
        if (reg_rd_i) begin
            case (maddr)
                ADDR_VAL0:   n.rdata = s.value[0]; // [R1]
                ADDR_VAL1:   n.rdata = s.value[1]; // [R1]
                ADDR_VAL2:   n.rdata = s.value[2]; // [R1]
                ADDR_VAL3:   n.rdata = s.value[3]; // [R1]
                ADDR_LOCAL:  n.rdata = s.local_temp;
                ADDR_LOW:    n.rdata = s.low;
                ADDR_HIGH:   n.rdata = s.high;
                ADDR_CFG1:   n.rdata = s.cfg1;
                ADDR_MONCFG: n.rdata = s.moncfg;
                ADDR_CPUCFG: n.rdata = s.cpucfg;
                ADDR_OFF0:   n.rdata = s.offs[0];
                ADDR_OFF1:   n.rdata = s.offs[1];
                ADDR_OFF2:   n.rdata = s.offs[2];
                ADDR_OFF3:   n.rdata = s.offs[3];
                ADDR_STAT3: begin
                    n.rdata = s.stat3;
                    n.stat3 = ZERO8;
                end
                ADDR_STATX: begin
                    n.rdata = s.statx;
                    n.statx = ZERO8;
                end
                default:     n.rdata = ZERO8;
            endcase
        end

        // The local result keeps its top eight bits only.
        if (local_valid_i) begin
            n.local_temp = local_temp_i[9:2]; // [R17]
        end

        // Incoming samples: bad frames and error codes never touch the round maximum.
        if (smp_valid_i) begin
            if (!smp_fcs_ok_i) begin
                n.stat3[ST_CERR] = 1'b1; // [R10]
            end else if (is_err(smp_data_i)) begin
                n.stat3[ST_DERR] = 1'b1; // [R7] [R9]
            end else if (!s.rgood[smp_cpu_i] ||
                         ($signed(smp_data_i) > $signed(s.rmax[smp_cpu_i]))) begin
                n.rmax[smp_cpu_i]  = smp_data_i; // [R18]
                n.rgood[smp_cpu_i] = 1'b1;
            end
        end

        // Round timer; disabling stops polling and abandons the partial interval.
        n.ncpu = 3'({1'b0, s.cpucfg[NCPU_MSB:NCPU_LSB]} + 3'h1); // [R19]
        if (!s.moncfg[MON_EN_BIT]) begin
            n.timer = '0; // [R20]
            n.run   = 1'b0;
            n.rdcnt = '0;
            n.acc   = '0;
            n.igood = '0;
            n.rgood = '0;
        end else if (s.timer == 16'h0) begin
            n.poll  = 1'b1; // [R20]
            n.timer = 16'(round_cyc - 16'h1); // [R6]
            n.run   = 1'b1;
            rnd_end = s.run;
        end else begin
            n.timer = 16'(s.timer - 16'h1);
        end

        // Round end: fold hottest domain of each channel into its sum.
        if (rnd_end) begin
            int_end = (s.rdcnt >= reads_m1); // [R5]
            n.rdcnt = int_end ? 13'h0 : 13'(s.rdcnt + 13'h1);
            n.upd   = int_end;
            for (int c = 0; c < CTP_CH; c++) begin
                // An errored read adds zero, which biases the average cold.
                sum = s.acc[c] + (s.rgood[c] ? ACC_W'($signed(s.rmax[c])) : '0); // [R8] [R22]
                good = s.igood[c] | s.rgood[c];
                n.acc[c] = int_end ? '0 : sum;
                n.igood[c] = int_end ? 1'b0 : good;
                n.rgood[c] = 1'b0;
                n.rmax[c] = SMP_MIN;
                if (int_end && good && (c < 32'(s.ncpu))) begin
                    avg  = ACC_W'($signed(sum) >>> shift); // [R4]
                    corr = sat_add(avg[TEMP_MSB:TEMP_LSB], s.offs[c]); // [R3]
                    n.value[c] = corr; // [R5] [R9]
                    if (($signed(corr) < $signed(s.low)) ||
                        ($signed(corr) > $signed(s.high))) begin
                        if (c == 0) begin
                            n.stat3[ST_LIM0] = 1'b1; // [R21] [R12]
                        end else begin
                            n.statx[ST_LIM1 + c - 1] = 1'b1; // [R21] [R12]
                        end
                    end
                end
            end
        end

        // Alert follows the status bits that will be held next cycle.
        n.alert_n = !(n.stat3[ST_LIM0] | n.stat3[ST_DERR] | n.stat3[ST_CERR] |
                      (|n.statx[ST_LIM1 + 2:ST_LIM1])); // [R11] [R12]

        // Swap side effects for the hysteresis and fan-zone logic elsewhere.
        n.swap = s.cfg1[SWAP_BIT]; // [R13]
        n.hyst = s.cfg1[SWAP_BIT]; // [R15]
        for (int f = 0; f < FAN_OUTS; f++) begin
            n.fz[f] = s.cfg1[SWAP_BIT] &&
                      (fan_behavior_i[f * BEHAV_W +: BEHAV_W] == 3'h0); // [R16]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers; reset values are constants and the limits take their defaults.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            s         <= '0;
            s.low     <= LOW_RST; // [R2]
            s.high    <= HIGH_RST; // [R2]
            s.rmax    <= {CTP_CH{SMP_MIN}};
            s.alert_n <= 1'b1;
            s.ncpu    <= 3'h1;
        end else begin
            s <= n;
        end
    end

    assign reg_rdata_o      = s.rdata;
    assign poll_start_o     = s.poll;
    assign poll_cpu_count_o = s.ncpu;
    assign smbalert_n_o     = s.alert_n;
    assign swap_mode_o      = s.swap;
    assign hyst_swap_o      = s.hyst;
    assign fan_zone_swap_o  = s.fz;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    sequence good_err_sample;
        smp_valid_i && smp_fcs_ok_i && is_err(smp_data_i);
    endsequence

    sequence swapped_value_read;
        reg_rd_i && s.cfg1[SWAP_BIT] && (reg_addr_i == ADDR_R1_VAL);
    endsequence

    a_alert_tracks_status: assert property (smbalert_n_o == !((|s.stat3[2:0]) ||
        (|s.statx[5:3]))) else $error("alert differs from status"); // [R11] [R12]
    a_data_err_flag: assert property (good_err_sample |=> s.stat3[ST_DERR] ##0 !smbalert_n_o)
        else $error("data error not flagged"); // [R7]
    a_comm_err_flag: assert property (smp_valid_i && !smp_fcs_ok_i |=> s.stat3[ST_CERR])
        else $error("checksum error not flagged"); // [R10]
    a_value_on_interval: assert property (s.value != $past(s.value) |-> s.upd)
        else $error("value changed outside interval end"); // [R5]
    a_round_period: assert property (poll_start_o |-> s.timer == 16'($past(round_cyc) - 16'h1))
        else $error("round length wrong"); // [R6]
    a_no_poll_disabled: assert property (!s.moncfg[MON_EN_BIT] |=> !poll_start_o)
        else $error("poll while disabled"); // [R20]
    a_swap_read_path: assert property (swapped_value_read |=> reg_rdata_o == $past(s.value[0]))
        else $error("swap read wrong"); // [R13] [R14]
    a_fan_zone_gate: assert property (fan_zone_swap_o[0] == $past(s.cfg1[SWAP_BIT] &&
        fan_behavior_i[2:0] == 3'h0)) else $error("fan zone swap wrong"); // [R16]
    a_hyst_follows: assert property (hyst_swap_o == $past(s.cfg1[SWAP_BIT]))
        else $error("hysteresis swap mismatch"); // [R15]
    a_local_store: assert property (local_valid_i |=> s.local_temp == $past(local_temp_i[9:2]))
        else $error("local value not stored"); // [R17]
    a_limit_reset: assert property (disable iff (1'b0) !reset_n_i |=> s.low == LOW_RST &&
        s.high == HIGH_RST) else $error("limit defaults wrong"); // [R2]
endmodule : ctp_postproc
`default_nettype wire

//--- shared/ctp_pkg.sv
// Contract
// [R1] Readings of CPU addresses 0x30..0x33 land in registers 0x33, 0x1A, 0x1B, 0x1C.
// [R2] All channels share one low limit (reset cpu_limit_status_extra) and one high limit (reset 0x00).
// [R3] Each channel adds its own signed 8-bit offset, one count per degree.
// [R4] Reads averaged over a count chosen by bits [2:0] of register 0x36.
// [R5] Value registers change only once per smoothing interval.
// [R6] A round lasts 67 bit times per CPU plus a 14 us idle gap.
// [R7] An error code 0x8000..0x8003 sets bit 1 of register 0x43.
// [R8] An error code adds zero to the averaging sum.
// [R9] An error code never reaches a value register.
// [R10] A bad frame checksum sets bit 2 of register 0x43.
// [R11] Alert asserts while the data or communications error bit is set.
// [R12] Per-channel limit bits at 0x43 bit 0 and cpu_limit_status_extra bits 3..5 also alert.
// [R13] Bit 4 of register 0x36 selects swap mode, channel 0 at remote-1 locations.
// [R14] Swap mode exchanges value, limit and offset register locations in pairs.
// [R15] Swap mode exchanges the remote-2 and local hysteresis nibbles.
// [R16] Fan zone moves to channel 0 only when its behaviour field is 000.
// [R17] Register 0x26 holds the top 8 bits of the local sensor result.
// [R18] Only the hottest domain of each CPU is recorded.
// [R19] Bits [7:6] of register 0x88 set how many CPUs are polled.
// [R20] Polling runs only while bit 4 of register 0x40 is set.
// [R21] Limit bit sets when corrected average is below low or above high, signed.
// [R22] Accumulator holds the largest read count of 16-bit samples without overflow.
`default_nettype none
package ctp_pkg;
    localparam int unsigned CTP_CH       = 4;
    localparam logic [7:0] ADDR_VAL0     = 8'h33;
    localparam logic [7:0] ADDR_VAL1     = 8'h1a;
    localparam logic [7:0] ADDR_VAL2     = 8'h1b;
    localparam logic [7:0] ADDR_VAL3     = 8'h1c;
    localparam logic [7:0] ADDR_LOCAL    = 8'h26;
    localparam logic [7:0] ADDR_LOW      = 8'h34;
    localparam logic [7:0] ADDR_HIGH     = 8'h35;
    localparam logic [7:0] ADDR_CFG1     = 8'h36;
    localparam logic [7:0] ADDR_MONCFG   = 8'h40;
    localparam logic [7:0] ADDR_STAT3    = 8'h43;
    localparam logic [7:0] ADDR_STATX    = 8'h81;
    localparam logic [7:0] ADDR_CPUCFG   = 8'h88;
    localparam logic [7:0] ADDR_OFF0     = 8'h94;
    localparam logic [7:0] ADDR_OFF1     = 8'h95;
    localparam logic [7:0] ADDR_OFF2     = 8'h96;
    localparam logic [7:0] ADDR_OFF3     = 8'h97;
    localparam logic [7:0] ADDR_R1_VAL   = 8'h25;
    localparam logic [7:0] ADDR_R1_LOW   = 8'h4e;
    localparam logic [7:0] ADDR_R1_HIGH  = 8'h4f;
    localparam logic [7:0] ADDR_R1_OFF   = 8'h70;
    localparam logic [7:0] LOW_RST       = 8'h81;
    localparam logic [7:0] HIGH_RST      = 8'h00;
    localparam logic [7:0] ZERO8         = 8'h00;
    localparam int unsigned SMOOTH_LSB   = 0;
    localparam int unsigned SMOOTH_MSB   = 2;
    localparam int unsigned SWAP_BIT     = 4;
    localparam int unsigned MON_EN_BIT   = 4;
    localparam int unsigned NCPU_LSB     = 6;
    localparam int unsigned NCPU_MSB     = 7;
    localparam int unsigned ST_LIM0      = 0;
    localparam int unsigned ST_DERR      = 1;
    localparam int unsigned ST_CERR      = 2;
    localparam int unsigned ST_LIM1      = 3;
    localparam logic [15:0] ERR_LO       = 16'h8000;
    localparam logic [15:0] ERR_HI       = 16'h8003;
    localparam logic [15:0] SMP_MIN      = 16'h8000;
    localparam int unsigned TEMP_MSB     = 13;
    localparam int unsigned TEMP_LSB     = 6;
    localparam int unsigned SMP_W        = 16;
    localparam int unsigned MAX_SHIFT    = 12;
    localparam int unsigned ACC_W        = SMP_W + MAX_SHIFT;
    localparam int unsigned CLK_NS       = 100;
    localparam int unsigned T_BIT_NS     = 1000;
    localparam int unsigned BITS_PER_RD  = 67;
    localparam int unsigned T_IDLE_NS    = 14000;
    localparam int unsigned IDLE_CYC     = (T_IDLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned BIT_CYC_DEF  = (T_BIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned FAN_OUTS     = 3;
    localparam int unsigned BEHAV_W      = 3;
endpackage : ctp_pkg
`default_nettype wire

//--- testbench/ctp_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// Group of CPUs that answers every polling round with two domain readings each.
module ctp_cpu_model (
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    input  wire logic        poll_start_i,
    input  wire logic [2:0]  count_i,
    input  wire logic [1:0]  mode_i,
    input  wire logic [1:0]  err_code_i,
    output logic             smp_valid_o,
    output logic [1:0]       smp_cpu_o,
    output logic [15:0]      smp_data_o,
    output logic             smp_fcs_ok_o
);
    logic [3:0] idx;
    logic [7:0] t;
    ////////////////////////////////////////////////////////////
    // Domain 1 runs three degrees cooler, so only domain 0 may be kept.
    assign t = 8'd20 + 8'd5 * {6'h0, idx[2:1]} - (idx[0] ? 8'd3 : 8'd0);
    // Answers follow the poll back to back; between rounds the idle lines toggle,
    // so a stale value can never pass for a fresh one.
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            idx          <= 4'hf;
            smp_valid_o  <= 1'b0;
            smp_cpu_o    <= 2'h0;
            smp_data_o   <= 16'h0000;
            smp_fcs_ok_o <= 1'b0;
        end else if (poll_start_i) begin
            idx         <= 4'h0;
            smp_valid_o <= 1'b0;
        end else if (idx < {count_i, 1'b0}) begin
            idx          <= idx + 4'h1;
            smp_valid_o  <= 1'b1;
            smp_cpu_o    <= idx[2:1];
            smp_data_o   <= (mode_i == 2'd1 && idx[2:1] == 2'd0) ? {14'h2000, err_code_i}
                                                               : {{2{t[7]}}, t, 6'h00};
            smp_fcs_ok_o <= !(mode_i == 2'd2 && idx[2:1] == 2'd0);
        end else begin
            smp_valid_o  <= 1'b0;
            smp_cpu_o    <= ~smp_cpu_o;
            smp_data_o   <= ~smp_data_o;
            smp_fcs_ok_o <= ~smp_fcs_ok_o;
        end
    end
endmodule : ctp_cpu_model
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ctp_pkg::*;
    typedef struct packed { logic [7:0] a; logic [7:0] d; } ctp_exp_s;
    localparam logic [7:0]  VADDR [4] = '{ADDR_VAL0, ADDR_VAL1, ADDR_VAL2, ADDR_VAL3};
    // Low limit, high limit, expected 0x43 and cpu_limit_status_extra per row.
    localparam logic [31:0] LIM [3]   = '{32'h8100_0138, 32'h7e7f_0138, 32'h817f_0000};
    logic        mclk_i, reset_n_i, reg_wr_i, reg_rd_i, smp_valid_i, smp_fcs_ok_i;
    logic        local_valid_i, poll_start_o, smbalert_n_o, swap_mode_o, hyst_swap_o;
    logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic [1:0]  smp_cpu_i, mode, ecode;
    logic [15:0] smp_data_i;
    logic [9:0]  local_temp_i;
    logic [8:0]  fan_behavior_i;
    logic [2:0]  poll_cpu_count_o, fan_zone_swap_o;
    logic        rd_q = 1'b0;
    logic [31:0] rnd;
    logic [7:0]  off [4];
    ctp_exp_s    q [$];
    ctp_exp_s    note;
    int          bad_count = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          gap;
    ////////////////////////////////////////////////////////////
    ctp_postproc #(.BIT_CYC(1)) i_ctp_postproc (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .smp_valid_i(smp_valid_i), .smp_cpu_i(smp_cpu_i),
        .smp_data_i(smp_data_i), .smp_fcs_ok_i(smp_fcs_ok_i),
        .local_valid_i(local_valid_i), .local_temp_i(local_temp_i),
        .fan_behavior_i(fan_behavior_i), .poll_start_o(poll_start_o),
        .poll_cpu_count_o(poll_cpu_count_o), .smbalert_n_o(smbalert_n_o),
        .swap_mode_o(swap_mode_o), .hyst_swap_o(hyst_swap_o),
        .fan_zone_swap_o(fan_zone_swap_o));
    ctp_cpu_model i_ctp_cpu_model (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .poll_start_i(poll_start_o),
        .count_i(poll_cpu_count_o), .mode_i(mode), .err_code_i(ecode),
        .smp_valid_o(smp_valid_i), .smp_cpu_o(smp_cpu_i), .smp_data_o(smp_data_i),
        .smp_fcs_ok_o(smp_fcs_ok_i));
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            $display("unexpected %s: expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        q.push_back('{a: a, d: e});
        @(posedge mclk_i);
        reg_rd_i   <= 1'b0;
    endtask : rd
    // Waits for n round pulses; gap keeps the length of the last whole wait.
    task automatic wp(input int n);
        repeat (n) begin
            gap = 0;
            do begin
                @(posedge mclk_i);
                gap++;
            end while (poll_start_o !== 1'b1 && gap < 2000);
            if (poll_start_o !== 1'b1) chk("poll pulse", 16'h1, {15'h0, poll_start_o});
        end
    endtask : wp
    task automatic results();
        if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end
    // Read data stands from the cycle after the strobe; match it with the oldest note.
    always @(posedge mclk_i) begin
        rd_q <= reg_rd_i;
        if (rd_q === 1'b1 && q.size() > 0) begin
            note = q.pop_front();
            chk($sformatf("data at %h", note.a), {8'h00, note.d}, {8'h00, reg_rdata_o});
        end
    end
    // A hang is cut short well beyond the roughly 12000 cycles the run needs.
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            bad_count++;
            results();
        end
    end
    // Main sequence; sample traffic stays away from the status reads.
    initial begin
        {reset_n_i, reg_wr_i, reg_rd_i, local_valid_i, mode, ecode} = '0;
        {reg_addr_i, reg_wdata_i, local_temp_i, fan_behavior_i} = '0;
        rnd = 32'h74fe8009;
        repeat (6) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        rd(ADDR_LOW, LOW_RST);
        rd(ADDR_HIGH, HIGH_RST);
        rd(8'h00, ZERO8); // Unmapped address reads zero.
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            off[i] = {4'h0, rnd[3:0]};
            wr(ADDR_OFF0 + 8'(i), off[i]);
            rd(ADDR_OFF0 + 8'(i), off[i]);
        end
        wr(ADDR_HIGH, 8'h7f);
        wr(ADDR_CPUCFG, 8'hc0);
        wr(ADDR_MONCFG, 8'h10);
        local_temp_i  <= rnd[13:4];
        local_valid_i <= 1'b1;
        @(posedge mclk_i);
        local_valid_i <= 1'b0;
        rd(ADDR_LOCAL, rnd[13:6]);
        wp(3);
        for (int i = 0; i < 4; i++) rd(VADDR[i], 8'(20 + 5 * i) + off[i]);
        mode  <= 2'd1;
        ecode <= rnd[1:0];
        wp(3);
        repeat (20) @(posedge mclk_i);
        chk("alert", 16'h0, {15'h0, smbalert_n_o});
        rd(ADDR_VAL0, 8'd20 + off[0]);
        rd(ADDR_STAT3, 8'h02);
        mode <= 2'd2;
        wp(3);
        repeat (20) @(posedge mclk_i);
        chk("alert", 16'h0, {15'h0, smbalert_n_o});
        rd(ADDR_STAT3, 8'h04);
        mode <= 2'd0;
        repeat (3) @(posedge mclk_i);
        chk("alert", 16'h1, {15'h0, smbalert_n_o});
        for (int k = 0; k < 3; k++) begin
            wr(ADDR_LOW, LIM[k][31:24]);
            wr(ADDR_HIGH, LIM[k][23:16]);
            wp(3);
            repeat (20) @(posedge mclk_i);
            chk("alert", {15'h0, LIM[k][15:8] == 8'h00}, {15'h0, smbalert_n_o});
            rd(ADDR_STAT3, LIM[k][15:8]);
            rd(ADDR_STATX, LIM[k][7:0]);
        end
        wr(ADDR_CFG1, 8'h10);
        fan_behavior_i <= 9'b000_101_000;
        repeat (3) @(posedge mclk_i);
        chk("swap mode", 16'h1, {15'h0, swap_mode_o});
        chk("hysteresis swap", 16'h1, {15'h0, hyst_swap_o});
        chk("fan zone", 16'h5, {13'h0, fan_zone_swap_o});
        rd(ADDR_R1_VAL, 8'd20 + off[0]);
        rd(ADDR_VAL0, ZERO8);
        rd(ADDR_R1_HIGH, 8'h7f);
        rd(ADDR_R1_OFF, off[0]);
        wr(ADDR_CFG1, 8'h00);
        repeat (3) @(posedge mclk_i);
        chk("fan zone", 16'h0, {13'h0, fan_zone_swap_o});
        // Three pulses, so the measured round is loaded with the new count for sure.
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_CPUCFG, 8'(k << 6));
            wp(3);
            chk("cpu count", 16'(k + 1), {13'h0, poll_cpu_count_o});
            chk("round length", 16'((k + 1) * BITS_PER_RD + IDLE_CYC), 16'(gap));
        end
        // Two reads per interval, the first one errored: zero enters the sum.
        mode <= 2'd1;
        wr(ADDR_CFG1, 8'h01);
        wp(1);
        mode <= 2'd0;
        rd(ADDR_VAL0, 8'd20 + off[0]);
        wp(1);
        rd(ADDR_VAL0, 8'd10 + off[0]);
        wr(ADDR_MONCFG, 8'h00);
        repeat (3) @(posedge mclk_i);
        gap = 0;
        repeat (600) begin
            @(posedge mclk_i);
            if (poll_start_o === 1'b1) gap++;
        end
        chk("pulses while off", 16'h0, 16'(gap));
        results();
    end
endmodule : testbench
`default_nettype wire
